// file: logic/carry_pkg.sv
// Shared constants, encodings and states for the carry-cycle DMA sequencer
package carry_pkg;
  // ==========================================================
  // Field encodings
  localparam logic [1:0] COUNT_HOLD   = 2'h0;
  localparam logic [1:0] COUNT_UP     = 2'h1;
  localparam logic [1:0] COUNT_DOWN   = 2'h2;
  localparam logic [1:0] CHAIN_NONE   = 2'h0;
  localparam logic [1:0] CHAIN_ARRAY  = 2'h2;
  localparam logic [1:0] CHAIN_LINKED = 2'h3;
  localparam logic       WAY_TO_GPIB  = 1'h0;
  // ==========================================================
  // Chaining entry layout, big-endian bytes
  localparam logic [3:0] ADDR_LAST_BYTE   = 4'h3;
  localparam logic [3:0] COUNT_LAST_BYTE  = 4'h5;
  localparam logic [3:0] LINK_LAST_BYTE   = 4'h9;
  localparam logic [3:0] FETCH_FIRST      = 4'h0;
  localparam logic [15:0] CARRY_REMAIN    = 16'h0001;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [31:0] ADDR_ZERO       = 32'h0000_0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_LOAD, S_CMD, S_WAIT, S_MEM, S_REL, S_HELD
  } seq_state_e;
endpackage : carry_pkg

// file: logic/byte_stream_if.sv
// Valid/ready stream carrier between sequencer and its buffer
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 9);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// file: logic/two_entry_buffer.sv
// Two-entry registered buffer; head slot drives the output directly
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 9
) (
  input  wire logic   clk,
  input  wire logic   rst,
  byte_stream_if.snk  push_side,
  byte_stream_if.src  pop_side
);
  logic [WIDTH-1:0] head;
  logic [WIDTH-1:0] tail;
  logic             head_valid;
  logic             tail_valid;
  logic             push;
  logic             pop;

  // Full only when both slots hold a word, so ready is honest
  assign push_side.ready = !tail_valid;
  assign push            = push_side.valid && !tail_valid;
  assign pop             = head_valid && pop_side.ready;
  assign pop_side.data   = head;
  assign pop_side.valid  = head_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head       <= '0;
      tail       <= '0;
      head_valid <= 1'b0;
      tail_valid <= 1'b0;
    end else begin
      case ({pop, push})
        2'b01: begin
          if (!head_valid) begin
            head       <= push_side.data;
            head_valid <= 1'b1;
          end else begin
            tail       <= push_side.data;
            tail_valid <= 1'b1;
          end
        end
        2'b10: begin
          head       <= tail;
          head_valid <= tail_valid;
          tail_valid <= 1'b0;
        end
        2'b11: begin
          head <= tail_valid ? tail : push_side.data;
          if (tail_valid) begin
            tail <= push_side.data;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule : two_entry_buffer

// file: logic/carry_cycle_dma_sequencer.sv
// Two-channel byte DMA sequencer with carry-cycle command insertion
`timescale 1ns/1ns
// Summary of operation
// - Channel 0 moves first n-1 bytes flyby
// - Channel 0 address counts up or down
// - Array uses entry count; linked follows links
// - Channel 1 sends command, then final byte
// - Line flags show controller irq, berr, sync
// - Remaining count 1; further requests blocked
// - Completion plus sync raises line transition
// - Config write clears sync; abort channel 1
module carry_cycle_dma_sequencer
  import carry_pkg::*;
#(
  parameter int AW = 32,
  parameter int CW = 16
) (
  input  wire logic          SYS_CLK,
  input  wire logic          RESET,
  input  wire logic          CFG_WRITE,
  input  wire logic          CARRY_CYCLE_ENABLE,
  input  wire logic          TRANSFER_WAY,
  input  wire logic          STATUS_CLEAR,
  input  wire logic          CH0_START,
  input  wire logic          CH0_ABORT,
  input  wire logic [1:0]    CH0_CHAIN_MODE,
  input  wire logic [1:0]    CH0_COUNT_MODE,
  input  wire logic [AW-1:0] CH0_MEM_ADDR,
  input  wire logic [CW-1:0] CH0_MEM_COUNT,
  input  wire logic [AW-1:0] CH0_BASE_ADDR,
  input  wire logic [CW-1:0] CH0_BASE_COUNT,
  input  wire logic          CH1_START,
  input  wire logic          CH1_ABORT,
  input  wire logic [1:0]    CH1_CHAIN_MODE,
  input  wire logic [AW-1:0] CH1_BASE_ADDR,
  input  wire logic [CW-1:0] CH1_BASE_COUNT,
  output      logic          MEM_REQ,
  output      logic          MEM_WRITE,
  output      logic [AW-1:0] MEM_ADDR,
  output      logic [7:0]    MEM_WDATA,
  input  wire logic          MEM_ACK,
  input  wire logic          MEM_BERR,
  input  wire logic [7:0]    MEM_RDATA,
  input  wire logic          CTL_DREQ,
  input  wire logic          CTL_INT,
  input  wire logic          GPIB_SYNC,
  input  wire logic [7:0]    IN_DATA,
  output      logic          CTL_DACK,
  output      logic [7:0]    OUT_DATA,
  output      logic          OUT_AUX,
  output      logic          OUT_VALID,
  input  wire logic          OUT_READY,
  output      logic          CH0_COMPLETE,
  output      logic          CH0_FAULT,
  output      logic          CH1_COMPLETE,
  output      logic          CH1_FAULT,
  output      logic [CW-1:0] CH1_REMAIN,
  output      logic          LINE_STATE,
  output      logic          LINE_TRANSITION
);
  // ==========================================================
  // Pin synchronisers
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  logic        dreq;
  logic        ctl_int;
  logic        gpib_sync;
  logic [7:0]  in_byte;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {CTL_DREQ, CTL_INT, GPIB_SYNC, IN_DATA};
      pin_sync <= pin_meta;
    end
  end
  assign {dreq, ctl_int, gpib_sync, in_byte} = pin_sync;

  // ==========================================================
  // Output buffer toward the controller: {aux tag, byte}
  byte_stream_if #(.WIDTH(9)) fill_if ();
  byte_stream_if #(.WIDTH(9)) drain_if ();

  two_entry_buffer #(.WIDTH(9)) out_buffer (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .push_side (fill_if),
    .pop_side  (drain_if)
  );
  assign drain_if.ready = OUT_READY;
  assign OUT_DATA       = drain_if.data[7:0];
  assign OUT_AUX        = drain_if.data[8];
  assign OUT_VALID      = drain_if.valid;

  // ==========================================================
  // Sequencer
  seq_state_e    state;
  logic          chan;
  logic          ch0_run;
  logic          ch1_run;
  logic          c1_entry;
  logic [1:0]    chain;
  logic [AW-1:0] mem_addr;
  logic [CW-1:0] count;
  logic [AW-1:0] base_addr;
  logic [CW-1:0] entries_left;
  logic [3:0]    fetch_idx;
  logic [AW-1:0] ent_addr;
  logic [CW-1:0] ent_count;
  logic [AW-1:0] ent_link;
  logic          push_valid;
  logic [8:0]    push_data;
  logic          berr_latch;
  logic          sync_det;
  logic          more_entries;
  logic          acked;
  logic          to_gpib;

  assign to_gpib      = (TRANSFER_WAY == WAY_TO_GPIB);
  assign acked        = MEM_REQ && MEM_ACK;
  assign more_entries = (chain == CHAIN_LINKED) ? (ent_link != ADDR_ZERO)
                      : ((chain == CHAIN_ARRAY) && (entries_left != COUNT_ZERO));
  assign fill_if.valid = push_valid;
  assign fill_if.data  = push_data;

  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic [1:0] m);
    case (m)
      COUNT_UP:   step_addr = a + AW'(1);
      COUNT_DOWN: step_addr = a - AW'(1);
      default:    step_addr = a;
    endcase
  endfunction : step_addr

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= S_IDLE;    chan <= 1'b0;        c1_entry <= 1'b0;
      chain <= CHAIN_NONE; mem_addr <= '0;      count <= '0;
      base_addr <= '0;    entries_left <= '0;  fetch_idx <= FETCH_FIRST;
      ent_addr <= '0;     ent_count <= '0;     ent_link <= '0;
      MEM_REQ <= 1'b0;    MEM_WRITE <= 1'b0;   MEM_ADDR <= '0;
      MEM_WDATA <= BYTE_ZERO; CTL_DACK <= 1'b0; push_valid <= 1'b0;
      push_data <= '0;    CH1_REMAIN <= '0;
    end else begin
      CTL_DACK   <= 1'b0;
      push_valid <= 1'b0;
      if (acked && MEM_BERR) begin
        MEM_REQ <= 1'b0;
        state   <= S_IDLE;
      end else if ((chan == 1'b0 && CH0_ABORT) || (chan == 1'b1 && CH1_ABORT)) begin
        MEM_REQ <= 1'b0;
        state   <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            if (ch0_run && !CH0_COMPLETE) begin
              chan <= 1'b0;
              chain <= CH0_CHAIN_MODE;
              if (CH0_CHAIN_MODE == CHAIN_NONE) begin
                mem_addr <= CH0_MEM_ADDR;
                count <= CH0_MEM_COUNT;
                state <= S_WAIT;
              end else begin
                base_addr <= CH0_BASE_ADDR;
                entries_left <= CH0_BASE_COUNT;
                fetch_idx <= FETCH_FIRST;
                state <= S_FETCH;
              end
            end else if (ch1_run && CH0_COMPLETE && CARRY_CYCLE_ENABLE) begin
              chan <= 1'b1;
              c1_entry <= 1'b0;
              chain <= CH1_CHAIN_MODE;
              base_addr <= CH1_BASE_ADDR;
              entries_left <= CH1_BASE_COUNT;
              fetch_idx <= FETCH_FIRST;
              state <= S_FETCH;
            end
          end
          S_FETCH: begin
            MEM_REQ <= 1'b1;
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= base_addr;
            if (acked) begin
              MEM_REQ <= 1'b0;
              base_addr <= base_addr + AW'(1);
              fetch_idx <= fetch_idx + 4'h1;
              if (fetch_idx <= ADDR_LAST_BYTE) ent_addr <= {ent_addr[AW-9:0], MEM_RDATA};
              else if (fetch_idx <= COUNT_LAST_BYTE) ent_count <= {ent_count[CW-9:0], MEM_RDATA};
              else ent_link <= {ent_link[AW-9:0], MEM_RDATA};
              if (fetch_idx == ((chain == CHAIN_LINKED) ? LINK_LAST_BYTE : COUNT_LAST_BYTE))
                state <= S_LOAD;
            end
          end
          S_LOAD: begin
            mem_addr <= ent_addr;
            count <= ent_count;
            fetch_idx <= FETCH_FIRST;
            if (chain == CHAIN_LINKED) base_addr <= ent_link;
            else entries_left <= entries_left - CW'(1);
            if (chan) CH1_REMAIN <= ent_count;
            state <= (chan && !c1_entry) ? S_CMD : S_WAIT;
          end
          S_CMD: begin
            MEM_REQ <= fill_if.ready;
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= mem_addr;
            if (acked) begin
              MEM_REQ <= 1'b0;
              push_valid <= 1'b1;
              push_data <= {1'b1, MEM_RDATA};
              c1_entry <= 1'b1;
              state <= S_FETCH;
            end
          end
          S_WAIT: begin
            if (dreq) state <= S_MEM;
          end
          S_MEM: begin
            MEM_REQ <= !to_gpib || fill_if.ready;
            MEM_WRITE <= !to_gpib;
            MEM_ADDR <= mem_addr;
            MEM_WDATA <= in_byte;
            if (acked) begin
              MEM_REQ <= 1'b0;
              CTL_DACK <= 1'b1;
              push_valid <= to_gpib;
              push_data <= {1'b0, MEM_RDATA};
              count <= count - CW'(1);
              if (chan) CH1_REMAIN <= count - CW'(1);
              else mem_addr <= step_addr(mem_addr, CH0_COUNT_MODE);
              state <= S_REL;
            end
          end
          S_REL: begin
            // The synchronised request lags the acknowledge, so wait for it to drop
            if (!dreq) begin
              if (chan && !more_entries && count == CARRY_REMAIN) state <= S_HELD;
              else if (count != COUNT_ZERO) state <= S_WAIT;
              else if (more_entries) state <= S_FETCH;
              else state <= S_IDLE;
            end
          end
          S_HELD: begin
            // Requests from the controller never reach the channel here
            state <= S_HELD;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Channel status
  logic ch_done_evt;
  logic bus_fault;
  assign ch_done_evt = (state == S_REL) && !dreq && (count == COUNT_ZERO) && !more_entries;
  // A bus error stops the channel for good; it must not go back and retry the byte
  assign bus_fault   = acked && MEM_BERR;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ch0_run <= 1'b0; ch1_run <= 1'b0;
      CH0_COMPLETE <= 1'b0; CH0_FAULT <= 1'b0;
      CH1_COMPLETE <= 1'b0; CH1_FAULT <= 1'b0;
    end else begin
      if (CH0_START) ch0_run <= 1'b1;
      else if (CH0_ABORT || (ch_done_evt && !chan) || (bus_fault && !chan)) ch0_run <= 1'b0;
      if (CH1_START) ch1_run <= 1'b1;
      else if (CH1_ABORT || (ch_done_evt && chan) || (bus_fault && chan)) ch1_run <= 1'b0;
      CH0_COMPLETE <= (ch_done_evt && !chan) || (CH0_COMPLETE && !STATUS_CLEAR && !CH0_START);
      CH1_COMPLETE <= (ch_done_evt && chan) || (CH1_COMPLETE && !STATUS_CLEAR);
      CH0_FAULT <= (acked && MEM_BERR && !chan) || (CH0_FAULT && !STATUS_CLEAR);
      CH1_FAULT <= (acked && MEM_BERR && chan) || (CH1_FAULT && !STATUS_CLEAR);
    end
  end

  // ==========================================================
  // Line to channel 1: controller irq, bus error, handshake sync
  logic xfer_done;
  logic line_src;
  assign xfer_done = CARRY_CYCLE_ENABLE ? (state == S_HELD) : CH0_COMPLETE;
  assign line_src  = ctl_int || berr_latch || sync_det;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      berr_latch <= 1'b0; sync_det <= 1'b0;
      LINE_STATE <= 1'b0; LINE_TRANSITION <= 1'b0;
    end else begin
      // An event in the clearing cycle survives the clear
      berr_latch <= (acked && MEM_BERR) || (berr_latch && !CFG_WRITE);
      sync_det <= (xfer_done && gpib_sync) || (sync_det && !CFG_WRITE);
      LINE_STATE <= line_src;
      LINE_TRANSITION <= (line_src && !LINE_STATE) || (LINE_TRANSITION && !STATUS_CLEAR);
    end
  end

  // ==========================================================
  // Checks
  held_count_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state == S_HELD) |-> (CH1_REMAIN == CARRY_REMAIN))
    else $error("held channel 1 count is not one");
  held_block_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state == S_HELD) ##1 (state == S_HELD) |-> !CTL_DACK && !MEM_REQ)
    else $error("request served while channel 1 held");
  sync_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    CFG_WRITE && !(xfer_done && gpib_sync) |=> !sync_det)
    else $error("config write did not clear sync detector");
  line_edge_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    line_src && !LINE_STATE |=> LINE_STATE && LINE_TRANSITION)
    else $error("line transition flag not set");
  berr_line_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    acked && MEM_BERR && !CFG_WRITE |-> ##2 LINE_STATE)
    else $error("bus error not shown on line");
  addr_up_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    state == S_MEM && acked && !MEM_BERR && !CH0_ABORT && !chan && CH0_COUNT_MODE == COUNT_UP
    |=> mem_addr == $past(mem_addr) + AW'(1))
    else $error("channel 0 address did not count up");
  addr_down_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    state == S_MEM && acked && !MEM_BERR && !CH0_ABORT && !chan && CH0_COUNT_MODE == COUNT_DOWN
    |=> mem_addr == $past(mem_addr) - AW'(1))
    else $error("channel 0 address did not count down");
  aux_order_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    push_valid && push_data[8] |-> chan && c1_entry && state == S_FETCH)
    else $error("command byte outside channel 1 first entry");
  array_count_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    state == S_LOAD && chain == CHAIN_ARRAY && !CH0_ABORT && !CH1_ABORT
    |=> entries_left == $past(entries_left) - CW'(1))
    else $error("array entry count not consumed");
endmodule : carry_cycle_dma_sequencer

// file: bench/mem_partner.sv
// Behavioural byte memory answering the sequencer's bus accesses
`timescale 1ns/1ns
// ==========================================================
// Memory partner
module mem_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        berr_on,
  output      logic        ack,
  output      logic        berr,
  output      logic [7:0]  rdata
);
  logic [7:0] mem [0:255];
  int         wait_cnt;
  int         slow;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack      <= 1'b0;
      berr     <= 1'b0;
      rdata    <= 8'h00;
      wait_cnt <= 0;
      slow     <= 0;
    end else if (ack) begin
      ack      <= 1'b0;
      berr     <= 1'b0;
      // A released bus must not keep showing the last byte
      rdata    <= ~rdata;
      wait_cnt <= 0;
    end else if (req) begin
      if (wait_cnt >= slow) begin
        ack   <= 1'b1;
        berr  <= berr_on;
        rdata <= mem[addr[7:0]];
        if (write) mem[addr[7:0]] <= wdata;
        // Alternate prompt and slow answers
        slow  <= (slow == 0) ? 3 : 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : mem_partner

// file: bench/carry_cycle_dma_sequencer_tb.sv
// Self-checking bench for the carry-cycle DMA sequencer
`timescale 1ns/1ns
module carry_cycle_dma_sequencer_tb;
  import carry_pkg::*;
  // ==========================================================
  // Signals
  logic        SYS_CLK, RESET, CFG_WRITE, CARRY_CYCLE_ENABLE, TRANSFER_WAY, STATUS_CLEAR;
  logic        CH0_START, CH0_ABORT, CH1_START, CH1_ABORT, CTL_DREQ, CTL_INT, GPIB_SYNC;
  logic [1:0]  CH0_CHAIN_MODE, CH0_COUNT_MODE, CH1_CHAIN_MODE;
  logic [31:0] CH0_MEM_ADDR, CH0_BASE_ADDR, CH1_BASE_ADDR, MEM_ADDR;
  logic [15:0] CH0_MEM_COUNT, CH0_BASE_COUNT, CH1_BASE_COUNT, CH1_REMAIN;
  logic        MEM_REQ, MEM_WRITE, MEM_ACK, MEM_BERR, CTL_DACK, OUT_AUX, OUT_VALID;
  logic        OUT_READY, CH0_COMPLETE, CH0_FAULT, CH1_COMPLETE, CH1_FAULT;
  logic        LINE_STATE, LINE_TRANSITION, berr_on, pump;
  logic [7:0]  MEM_WDATA, MEM_RDATA, IN_DATA, OUT_DATA;
  logic [8:0]  q[$];
  int          n_errors, compares, cycles, gap;
  // ==========================================================
  // Instances
  carry_cycle_dma_sequencer DUT (.SYS_CLK(SYS_CLK), .RESET(RESET), .CFG_WRITE(CFG_WRITE),
    .CARRY_CYCLE_ENABLE(CARRY_CYCLE_ENABLE), .TRANSFER_WAY(TRANSFER_WAY),
    .STATUS_CLEAR(STATUS_CLEAR), .CH0_START(CH0_START), .CH0_ABORT(CH0_ABORT),
    .CH0_CHAIN_MODE(CH0_CHAIN_MODE), .CH0_COUNT_MODE(CH0_COUNT_MODE),
    .CH0_MEM_ADDR(CH0_MEM_ADDR), .CH0_MEM_COUNT(CH0_MEM_COUNT),
    .CH0_BASE_ADDR(CH0_BASE_ADDR), .CH0_BASE_COUNT(CH0_BASE_COUNT),
    .CH1_START(CH1_START), .CH1_ABORT(CH1_ABORT), .CH1_CHAIN_MODE(CH1_CHAIN_MODE),
    .CH1_BASE_ADDR(CH1_BASE_ADDR), .CH1_BASE_COUNT(CH1_BASE_COUNT), .MEM_REQ(MEM_REQ),
    .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_BERR(MEM_BERR), .MEM_RDATA(MEM_RDATA), .CTL_DREQ(CTL_DREQ), .CTL_INT(CTL_INT),
    .GPIB_SYNC(GPIB_SYNC), .IN_DATA(IN_DATA), .CTL_DACK(CTL_DACK), .OUT_DATA(OUT_DATA),
    .OUT_AUX(OUT_AUX), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .CH0_COMPLETE(CH0_COMPLETE), .CH0_FAULT(CH0_FAULT), .CH1_COMPLETE(CH1_COMPLETE),
    .CH1_FAULT(CH1_FAULT), .CH1_REMAIN(CH1_REMAIN), .LINE_STATE(LINE_STATE),
    .LINE_TRANSITION(LINE_TRANSITION));
  mem_partner partner (.clk(SYS_CLK), .rst(RESET), .req(MEM_REQ), .write(MEM_WRITE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .berr_on(berr_on), .ack(MEM_ACK), .berr(MEM_BERR),
    .rdata(MEM_RDATA));
  // ==========================================================
  // Clock, controller model, stream monitor, watchdog
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Controller drops its request after each acknowledge and waits before the next
  always @(posedge SYS_CLK) begin
    #1;
    if (CTL_DACK === 1'b1) begin
      CTL_DREQ = 1'b0;
      gap = 4;
    end else if (gap != 0) gap = gap - 1;
    else CTL_DREQ = pump;
  end
  always @(posedge SYS_CLK) begin
    if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) q.push_back({OUT_AUX, OUT_DATA});
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("MISMATCH watchdog expected done seen hang");
      end_sim;
    end
  end
  // ==========================================================
  // Helpers
  task step;
    @(posedge SYS_CLK);
    #1;
  endtask : step
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task end_sim;
    $display("Counts: %0d compares, %0d n_errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Abort both channels, clear status and rewrite the board config
  task prep(input logic carry);
    q.delete();
    CARRY_CYCLE_ENABLE = carry;
    CFG_WRITE = 1'b1;
    CH0_ABORT = 1'b1;
    CH1_ABORT = 1'b1;
    step;
    CFG_WRITE = 1'b0;
    CH0_ABORT = 1'b0;
    CH1_ABORT = 1'b0;
    // Status is cleared only once the abort has taken effect
    STATUS_CLEAR = 1'b1;
    step;
    STATUS_CLEAR = 1'b0;
  endtask : prep
  task expect_bytes(input logic [8:0] exp [5], input int n);
    int i;
    for (i = 0; i < 2000 && q.size() < n; i++) step;
    chk("stream length", 16'(n), 16'(q.size()));
    for (i = 0; i < n && q.size() > 0; i++) chk("stream byte", 16'(exp[i]), 16'(q.pop_front()));
  endtask : expect_bytes
  // ==========================================================
  // Scenarios
  task t_carry;
    int i;
    prep(1'b1);
    CH1_CHAIN_MODE = CHAIN_ARRAY;
    CH1_BASE_ADDR = 32'h0000_0080;
    CH1_BASE_COUNT = 16'h0002;
    CH0_COUNT_MODE = COUNT_UP;
    CH0_MEM_ADDR = 32'h0000_0040;
    CH0_MEM_COUNT = 16'h0003;
    CH1_START = 1'b1;
    step;
    CH1_START = 1'b0;
    CH0_START = 1'b1;
    step;
    CH0_START = 1'b0;
    OUT_READY = 1'b0;
    pump = 1'b1;
    repeat (40) step;
    OUT_READY = 1'b1;
    expect_bytes('{9'h0A1, 9'h0A2, 9'h0A3, 9'h15C, 9'h0D4}, 5);
    chk("ch0 complete", 16'h0001, 16'(CH0_COMPLETE));
    chk("ch1 remain", 16'h0001, CH1_REMAIN);
    repeat (60) step;
    chk("blocked requests", 16'h0000, 16'(q.size()));
    chk("ch1 complete", 16'h0000, 16'(CH1_COMPLETE));
    chk("transition before sync", 16'h0000, 16'(LINE_TRANSITION));
    GPIB_SYNC = 1'b1;
    for (i = 0; i < 20 && LINE_TRANSITION !== 1'b1; i++) step;
    chk("transition on sync", 16'h0001, 16'(LINE_TRANSITION));
    chk("line state on sync", 16'h0001, 16'(LINE_STATE));
    GPIB_SYNC = 1'b0;
    pump = 1'b0;
    repeat (4) step;
    prep(1'b0);
    repeat (4) step;
    chk("line state after config write", 16'h0000, 16'(LINE_STATE));
    $display("Test carry cycle done");
  endtask : t_carry
  task t_down;
    int i;
    prep(1'b0);
    CH0_COUNT_MODE = COUNT_DOWN;
    CH0_MEM_ADDR = 32'h0000_0042;
    CH0_MEM_COUNT = 16'h0003;
    CH0_START = 1'b1;
    step;
    CH0_START = 1'b0;
    pump = 1'b1;
    expect_bytes('{9'h0A3, 9'h0A2, 9'h0A1, 9'h000, 9'h000}, 3);
    for (i = 0; i < 50 && CH0_COMPLETE !== 1'b1; i++) step;
    chk("ch0 complete down", 16'h0001, 16'(CH0_COMPLETE));
    pump = 1'b0;
    GPIB_SYNC = 1'b1;
    for (i = 0; i < 20 && LINE_TRANSITION !== 1'b1; i++) step;
    chk("transition after complete", 16'h0001, 16'(LINE_TRANSITION));
    GPIB_SYNC = 1'b0;
    // Let the synchronised pin fall before the next config write
    repeat (3) step;
    $display("Test count down done");
  endtask : t_down
  task t_chain;
    prep(1'b0);
    CH0_COUNT_MODE = COUNT_UP;
    CH0_CHAIN_MODE = CHAIN_LINKED;
    CH0_BASE_ADDR = 32'h0000_00C0;
    // A zero entry count shows that linked chaining ignores it
    CH0_BASE_COUNT = 16'h0000;
    CH0_START = 1'b1;
    step;
    CH0_START = 1'b0;
    pump = 1'b1;
    expect_bytes('{9'h0A1, 9'h0A2, 9'h0A3, 9'h000, 9'h000}, 3);
    pump = 1'b0;
    CH0_CHAIN_MODE = CHAIN_NONE;
    $display("Test linked chain done");
  endtask : t_chain
  task t_listen;
    int i;
    prep(1'b0);
    TRANSFER_WAY = 1'b1;
    IN_DATA = 8'h3C;
    CH0_MEM_ADDR = 32'h0000_0050;
    CH0_MEM_COUNT = 16'h0002;
    CH0_START = 1'b1;
    step;
    CH0_START = 1'b0;
    pump = 1'b1;
    for (i = 0; i < 200 && CH0_COMPLETE !== 1'b1; i++) step;
    pump = 1'b0;
    chk("ch0 complete listen", 16'h0001, 16'(CH0_COMPLETE));
    chk("first stored byte", 16'h003C, 16'(partner.mem[8'h50]));
    chk("second stored byte", 16'h003C, 16'(partner.mem[8'h51]));
    chk("bytes sent while listening", 16'h0000, 16'(q.size()));
    TRANSFER_WAY = 1'b0;
    $display("Test listen done");
  endtask : t_listen
  task t_faults;
    int i;
    prep(1'b0);
    berr_on = 1'b1;
    CH0_COUNT_MODE = COUNT_UP;
    CH0_MEM_ADDR = 32'h0000_0040;
    CH0_MEM_COUNT = 16'h0001;
    CH0_START = 1'b1;
    step;
    CH0_START = 1'b0;
    pump = 1'b1;
    for (i = 0; i < 100 && CH0_FAULT !== 1'b1; i++) step;
    pump = 1'b0;
    berr_on = 1'b0;
    step;
    chk("ch0 fault", 16'h0001, 16'(CH0_FAULT));
    chk("line state on bus error", 16'h0001, 16'(LINE_STATE));
    chk("transition on bus error", 16'h0001, 16'(LINE_TRANSITION));
    chk("ch1 fault on ch0 error", 16'h0000, 16'(CH1_FAULT));
    // A faulted channel must not go back and retry the byte
    repeat (15) step;
    chk("no retry after bus error", 16'h0000, 16'(q.size()));
    prep(1'b0);
    repeat (3) step;
    chk("bus error latch cleared", 16'h0000, 16'(LINE_STATE));
    chk("fault cleared", 16'h0000, 16'(CH0_FAULT));
    CTL_INT = 1'b1;
    repeat (5) step;
    chk("line state on controller irq", 16'h0001, 16'(LINE_STATE));
    CTL_INT = 1'b0;
    repeat (5) step;
    chk("line state irq gone", 16'h0000, 16'(LINE_STATE));
    $display("Test faults done");
  endtask : t_faults
  // ==========================================================
  // Main sequence
  initial begin
    {CFG_WRITE, CARRY_CYCLE_ENABLE, TRANSFER_WAY, STATUS_CLEAR, CH0_START, CH0_ABORT} = '0;
    {CH1_START, CH1_ABORT, CTL_DREQ, CTL_INT, GPIB_SYNC, berr_on, pump} = '0;
    {CH0_CHAIN_MODE, CH0_COUNT_MODE, CH1_CHAIN_MODE} = '0;
    {CH0_MEM_ADDR, CH0_BASE_ADDR, CH1_BASE_ADDR, CH0_MEM_COUNT} = '0;
    {CH0_BASE_COUNT, CH1_BASE_COUNT, IN_DATA} = '0;
    OUT_READY = 1'b1;
    gap = 0;
    for (int k = 0; k < 256; k++) partner.mem[k] = 8'h00;
    partner.mem[8'h40] = 8'hA1;
    partner.mem[8'h41] = 8'hA2;
    partner.mem[8'h42] = 8'hA3;
    partner.mem[8'h90] = 8'h5C;
    partner.mem[8'hA0] = 8'hD4;
    // Carry array at an even base, even addresses, counts one then two
    partner.mem[8'h80] = 8'h00; partner.mem[8'h81] = 8'h00;
    partner.mem[8'h82] = 8'h00; partner.mem[8'h83] = 8'h90;
    partner.mem[8'h84] = 8'h00; partner.mem[8'h85] = 8'h01;
    partner.mem[8'h86] = 8'h00; partner.mem[8'h87] = 8'h00;
    partner.mem[8'h88] = 8'h00; partner.mem[8'h89] = 8'hA0;
    partner.mem[8'h8A] = 8'h00; partner.mem[8'h8B] = 8'h02;
    // Linked list for channel 0: two entries, the second link is zero
    partner.mem[8'hC3] = 8'h40; partner.mem[8'hC5] = 8'h02;
    partner.mem[8'hC9] = 8'hD0; partner.mem[8'hD3] = 8'h42;
    partner.mem[8'hD5] = 8'h01;
    RESET = 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1;
    RESET = 1'b0;
    step;
    t_carry;
    t_down;
    t_chain;
    t_listen;
    t_faults;
    end_sim;
  end
endmodule : carry_cycle_dma_sequencer_tb
